/* hdl/pit_pkg.sv */
// Package with register offsets, control word fields and timing constants for the timer.
package pit_pkg;
    localparam logic [2:0] ADDR_COUNTER0    = 3'h4;
    localparam logic [2:0] ADDR_COUNTER1    = 3'h5;
    localparam logic [2:0] ADDR_COUNTER2    = 3'h6;
    localparam logic [2:0] ADDR_CONTROL     = 3'h7;
    localparam int         CW_SEL_POS       = 6;
    localparam int         CW_ACC_POS       = 4;
    localparam int         CW_CFG_POS       = 1;
    localparam int         CW_BCD_POS       = 0;
    localparam logic [1:0] ACC_LATCH        = 2'h0;
    localparam logic [1:0] ACC_LOW          = 2'h1;
    localparam logic [1:0] ACC_HIGH         = 2'h2;
    localparam logic [1:0] ACC_PAIR         = 2'h3;
    localparam logic [2:0] CFG_TERMINAL     = 3'h0;
    localparam logic [2:0] CFG_RATE         = 3'h2;
    localparam logic [2:0] CFG_SQUARE       = 3'h3;
    localparam logic [5:0] CW_RESET_FIELDS  = 6'h30;
    localparam logic [7:0] DATA_RESET       = 8'h00;
    localparam int         MCLK_HZ          = 250000000;
    localparam int         INT_CLK_HZ       = 1000000;
    localparam int         INT_CLK_DIV      = MCLK_HZ / INT_CLK_HZ;
    localparam logic [7:0] INT_CLK_DIV_LAST = 8'(INT_CLK_DIV - 1);
endpackage : pit_pkg

/* hdl/pit_tick_div.sv */
// Divider that makes the one-cycle 1 MHz tick for the internally clocked counter.
`timescale 1ns/1ps
`default_nettype none
module pit_tick_div
    import pit_pkg::*;
(
    // Clock and reset.
    input  wire logic mclk_i,
    input  wire logic srst_i,
    // Tick.
    output logic      tick_o
);
    logic [7:0] div_count;

    always_ff @(posedge mclk_i) begin
        if (srst_i || div_count == INT_CLK_DIV_LAST) begin
            div_count <= 8'h00;
        end else begin
            div_count <= div_count + 8'h01;
        end
    end

    always_ff @(posedge mclk_i) begin
        tick_o <= !srst_i && (div_count == INT_CLK_DIV_LAST);
    end
endmodule // pit_tick_div
`default_nettype wire

/* hdl/pit_counter.sv */
// One 16-bit down counter with binary or decimal count, gate, and output configurations.
`timescale 1ns/1ps
`default_nettype none
module pit_counter
    import pit_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    // Count input and gate.
    input  wire logic        cnt_en_i,
    input  wire logic        gate_i,
    // Control from the register file.
    input  wire logic        mode_set_i,
    input  wire logic [2:0]  cfg_i,
    input  wire logic        bcd_i,
    input  wire logic        load_i,
    input  wire logic [15:0] load_value_i,
    // Status.
    output logic [15:0]      count_o,
    output logic             out_o
);
    logic [15:0] reload;
    logic        armed;
    logic        gate_prev;
    logic        gate_rise;
    logic        step;
    logic [15:0] next_count;
    logic [15:0] dec2;
    logic [15:0] sq_start;

    // Decimal decrement with per-digit borrow; binary is a plain decrement.
    function automatic logic [15:0] dec_one(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        logic        borrow;
        r = v;
        borrow = 1'b1;
        if (!bcd) begin
            r = v - 16'h0001;
        end else begin
            for (int d = 0; d < 4; d++) begin
                if (borrow) begin
                    if (v[d*4 +: 4] == 4'h0) begin
                        r[d*4 +: 4] = 4'h9;
                    end else begin
                        r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
                        borrow = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    assign gate_rise = gate_i && !gate_prev;
    assign step      = cnt_en_i && gate_i && armed;
    assign dec2      = dec_one(dec_one(count_o, bcd_i), bcd_i);
    assign sq_start  = {reload[15:1], 1'b0};

    always_comb begin
        next_count = dec_one(count_o, bcd_i);
        if (cfg_i[1:0] == CFG_SQUARE[1:0]) begin
            next_count = dec2;
            if (count_o == 16'h0002 && out_o && reload[0]) begin
                next_count = 16'h0001;
            end else if (count_o == 16'h0002 || count_o == 16'h0001) begin
                next_count = sq_start;
            end
        end else if (cfg_i[1:0] == CFG_RATE[1:0] && count_o == 16'h0001) begin
            next_count = reload;
        end
    end

    always_ff @(posedge mclk_i) begin
        gate_prev <= srst_i ? 1'b1 : gate_i;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            reload  <= 16'h0000;
            armed   <= 1'b0;
            count_o <= 16'h0000;
        end else if (mode_set_i) begin
            armed <= 1'b0;
        end else if (load_i) begin
            reload  <= load_value_i;
            count_o <= (cfg_i[1:0] == CFG_SQUARE[1:0]) ? {load_value_i[15:1], 1'b0} : load_value_i;
            armed   <= 1'b1;
        end else if (cfg_i[1] && gate_rise && armed) begin
            count_o <= (cfg_i[1:0] == CFG_SQUARE[1:0]) ? sq_start : reload;
        end else if (step) begin
            count_o <= next_count;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            out_o <= 1'b1;
        end else if (mode_set_i) begin
            out_o <= (cfg_i == CFG_TERMINAL) ? 1'b0 : 1'b1;
        end else if (load_i) begin
            out_o <= (cfg_i == CFG_TERMINAL) ? 1'b0 : 1'b1;
        end else if (cfg_i[1] && !gate_i) begin
            out_o <= 1'b1;
        end else if (step) begin
            if (cfg_i == CFG_TERMINAL && count_o == 16'h0001) begin
                out_o <= 1'b1;
            end else if (cfg_i[1:0] == CFG_RATE[1:0]) begin
                out_o <= (count_o != 16'h0002);
            end else if (cfg_i[1:0] == CFG_SQUARE[1:0]) begin
                // Odd divisors: the high half takes one extra count at one.
                if (count_o == 16'h0001 || (count_o == 16'h0002 && !(out_o && reload[0]))) begin
                    out_o <= !out_o;
                end
            end
        end
    end
endmodule // pit_counter
`default_nettype wire

/* hdl/pit_top.sv */
// Three-channel interval timer with a byte-wide data port and control word.
`timescale 1ns/1ps
`default_nettype none
module pit_top
    import pit_pkg::*;
(
    // Clock and reset.
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    // Byte-wide register port.
    input  wire logic [2:0] addr_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wdata_i,
    output logic [7:0]      rdata_o,
    // Counter clocks, gates and outputs.
    input  wire logic [1:0] ext_clk_i,
    input  wire logic [2:0] gate_i,
    output logic [2:0]      timer_out_o
);
    logic [1:0]  acc_mode  [3];
    logic [2:0]  cfg       [3];
    logic        bcd_mode  [3];
    logic        toggle    [3];
    logic        latched   [3];
    logic        rd_toggle [3];
    logic [15:0] hold      [3];
    logic [7:0]  low_buf   [3];
    logic [15:0] live      [3];
    logic [2:0]  cnt_out;
    logic [2:0]  cnt_en;
    logic [1:0]  ext_prev;
    logic        tick_1mhz;
    logic        cw_wr;
    logic [1:0]  cw_sel;
    logic [1:0]  cw_acc;
    logic [1:0]  data_ch;
    logic        data_hit;
    logic [2:0]  hi_rd_sel;
    logic [7:0]  rd_byte   [3];

    assign cw_wr  = wr_i && addr_i == ADDR_CONTROL;
    assign cw_sel = wdata_i[CW_SEL_POS +: 2];
    assign cw_acc = wdata_i[CW_ACC_POS +: 2];

    // Data location decode.
    always_comb begin
        data_hit = 1'b1;
        data_ch  = 2'h0;
        if (addr_i == ADDR_COUNTER0) begin
            data_ch = 2'h0;
        end else if (addr_i == ADDR_COUNTER1) begin
            data_ch = 2'h1;
        end else if (addr_i == ADDR_COUNTER2) begin
            data_ch = 2'h2;
        end else begin
            data_hit = 1'b0;
        end
    end

    pit_tick_div u_tick (
        .mclk_i (mclk_i),
        .srst_i (srst_i),
        .tick_o (tick_1mhz)
    );

    always_ff @(posedge mclk_i) begin
        ext_prev <= srst_i ? 2'h0 : ext_clk_i;
    end

    assign cnt_en[0] = ext_clk_i[0] && !ext_prev[0];
    assign cnt_en[1] = ext_clk_i[1] && !ext_prev[1];
    assign cnt_en[2] = tick_1mhz;

    generate
        for (genvar c = 0; c < 3; c++) begin : g_ch
            logic        sel_cw;
            logic        data_acc;
            logic        load_now;
            logic [15:0] load_val;
            logic [15:0] src;
            logic        hi_phase;
            logic        mode_set;
            logic [2:0]  cfg_now;

            assign sel_cw   = cw_wr && cw_sel == 2'(c);
            assign data_acc = data_hit && data_ch == 2'(c);
            assign hi_phase = (acc_mode[c] == ACC_HIGH) ||
                              (acc_mode[c] == ACC_PAIR && toggle[c]);
            assign load_now = wr_i && data_acc &&
                              (acc_mode[c] != ACC_PAIR || toggle[c]);
            assign load_val = (acc_mode[c] == ACC_LOW)  ? {8'h00, wdata_i} :
                              (acc_mode[c] == ACC_HIGH) ? {wdata_i, 8'h00} :
                              {wdata_i, low_buf[c]};
            assign src      = latched[c] ? hold[c] : live[c];
            assign mode_set = sel_cw && cw_acc != ACC_LATCH;
            assign cfg_now  = mode_set ? wdata_i[CW_CFG_POS +: 3] : cfg[c];

            // Control word fields; a latch command leaves mode untouched.
            always_ff @(posedge mclk_i) begin
                if (srst_i) begin
                    acc_mode[c] <= CW_RESET_FIELDS[5:4];
                    cfg[c]      <= CW_RESET_FIELDS[3:1];
                    bcd_mode[c] <= CW_RESET_FIELDS[0];
                end else if (sel_cw && cw_acc != ACC_LATCH) begin
                    acc_mode[c] <= cw_acc;
                    cfg[c]      <= wdata_i[CW_CFG_POS +: 3];
                    bcd_mode[c] <= wdata_i[CW_BCD_POS];
                end
            end

            // Write byte sequencing.
            always_ff @(posedge mclk_i) begin
                if (srst_i) begin
                    toggle[c]  <= 1'b0;
                    low_buf[c] <= DATA_RESET;
                end else if (sel_cw && cw_acc != ACC_LATCH) begin
                    toggle[c] <= 1'b0;
                end else if (wr_i && data_acc && acc_mode[c] == ACC_PAIR) begin
                    toggle[c] <= !toggle[c];
                    if (!toggle[c]) begin
                        low_buf[c] <= wdata_i;
                    end
                end
            end

            // Read byte sequencing and latch hold.
            always_ff @(posedge mclk_i) begin
                if (srst_i) begin
                    latched[c]   <= 1'b0;
                    rd_toggle[c] <= 1'b0;
                    hold[c]      <= 16'h0000;
                end else if (sel_cw && cw_acc == ACC_LATCH) begin
                    if (!latched[c]) begin
                        latched[c] <= 1'b1;
                        hold[c]    <= live[c];
                    end
                end else if (sel_cw) begin
                    rd_toggle[c] <= 1'b0;
                    latched[c]   <= 1'b0;
                end else if (rd_i && data_acc) begin
                    if (acc_mode[c] == ACC_PAIR) begin
                        rd_toggle[c] <= !rd_toggle[c];
                        if (rd_toggle[c]) begin
                            latched[c] <= 1'b0;
                        end
                    end else begin
                        latched[c] <= 1'b0;
                    end
                end
            end

            pit_counter u_cnt (
                .mclk_i       (mclk_i),
                .srst_i       (srst_i),
                .cnt_en_i     (cnt_en[c]),
                .gate_i       (gate_i[c]),
                .mode_set_i   (mode_set),
                .cfg_i        (cfg_now),
                .bcd_i        (bcd_mode[c]),
                .load_i       (load_now),
                .load_value_i (load_val),
                .count_o      (live[c]),
                .out_o        (cnt_out[c])
            );

            always_ff @(posedge mclk_i) begin
                timer_out_o[c] <= srst_i ? 1'b1 : cnt_out[c];
            end

            always_comb begin
                if (acc_mode[c] == ACC_PAIR) begin
                    hi_rd_sel[c] = rd_toggle[c];
                end else begin
                    hi_rd_sel[c] = hi_phase;
                end
                rd_byte[c] = hi_rd_sel[c] ? src[15:8] : src[7:0];
            end
        end
    endgenerate

    // Read data registered; control and unmapped locations read as zero.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rdata_o <= DATA_RESET;
        end else if (rd_i && data_hit) begin
            rdata_o <= rd_byte[data_ch];
        end else if (rd_i) begin
            rdata_o <= DATA_RESET;
        end
    end
endmodule // pit_top
`default_nettype wire

/* bench/pit_top_assertions.sv */
// Port-level assertions for the interval timer.
`timescale 1ns/1ps
`default_nettype none
module pit_top_assertions
    import pit_pkg::*;
(
    // Observed ports.
    input wire logic       mclk_i,
    input wire logic       srst_i,
    input wire logic [2:0] addr_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    input wire logic [1:0] ext_clk_i,
    input wire logic [2:0] gate_i,
    input wire logic [2:0] timer_out_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    property p_ctl_rd;
        rd_i && addr_i == ADDR_CONTROL |=> rdata_o == 8'h00;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("Control read not zero.");
    property p_low_rd;
        rd_i && addr_i < ADDR_COUNTER0 |=> rdata_o == 8'h00;
    endproperty
    a_low_rd: assert property (p_low_rd) else $error("Unmapped read not zero.");
    property p_rd_hold;
        !rd_i |=> $stable(rdata_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("Read data moved.");
    property p_cw30;
        wr_i && addr_i == ADDR_CONTROL && wdata_i == 8'h30 |-> ##[1:4] !timer_out_o[0];
    endproperty
    a_cw30: assert property (p_cw30) else $error("Output 0 not low.");
    property p_cw1;
        wr_i && addr_i == ADDR_CONTROL && wdata_i[7:6] == 2'h1 && wdata_i[5:4] != ACC_LATCH
            && wdata_i[3:1] == CFG_TERMINAL |-> ##[1:4] !timer_out_o[1];
    endproperty
    a_cw1: assert property (p_cw1) else $error("Output 1 not low.");
    property p_gate;
        (!gate_i[0] && !wr_i)[*5] |-> $stable(timer_out_o[0]);
    endproperty
    a_gate: assert property (p_gate) else $error("Output 0 moved while gated.");
    property p_hi2;
        $rose(timer_out_o[2]) |=> timer_out_o[2][*8];
    endproperty
    a_hi2: assert property (p_hi2) else $error("Output 2 high too short.");
    property p_lo2;
        $fell(timer_out_o[2]) |=> !timer_out_o[2][*8];
    endproperty
    a_lo2: assert property (p_lo2) else $error("Output 2 low too short.");
endmodule // pit_top_assertions
bind pit_top pit_top_assertions u_chk (
    .mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .ext_clk_i(ext_clk_i), .gate_i(gate_i),
    .timer_out_o(timer_out_o)
);
`default_nettype wire

/* bench/pit_host_bfm.sv */
// Host processor model driving the timer's byte-wide register port.
`timescale 1ns/1ps
`default_nettype none
module pit_host_bfm
    import pit_pkg::*;
(
    // Clock.
    input  wire logic       mclk_i,
    // Register port.
    output logic [2:0]      addr_o = 3'h0,
    output logic            wr_o = 1'b0,
    output logic            rd_o = 1'b0,
    output logic [7:0]      wdata_o = 8'h00,
    input  wire logic [7:0] rdata_i
);
    // Once released the data lines show the inverse byte.
    task automatic wr_byte(input logic [2:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge mclk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask
    task automatic rd_byte(input logic [2:0] a, output logic [7:0] d);
        @(negedge mclk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge mclk_i);
        rd_o = 1'b0;
        @(negedge mclk_i);
        d = rdata_i;
    endtask
    task automatic load16(input logic [2:0] a, input logic [7:0] cw, input logic [15:0] v);
        wr_byte(ADDR_CONTROL, cw);
        wr_byte(a, v[7:0]);
        wr_byte(a, v[15:8]);
    endtask
    task automatic rd16(input logic [2:0] a, output logic [15:0] v);
        rd_byte(a, v[7:0]);
        rd_byte(a, v[15:8]);
    endtask
endmodule // pit_host_bfm
`default_nettype wire

/* bench/test_pit_top.sv */
// Self-checking testbench for the three-channel interval timer.
`timescale 1ns/1ps
`default_nettype none
module test_pit_top
    import pit_pkg::*;
;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic [2:0]  addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [1:0]  ext_clk = 2'h0;
    logic [2:0]  gate = 3'h7;
    logic [2:0]  tout;
    logic [15:0] v;
    logic [7:0]  b;
    int          errors = 0;
    int          num_checks = 0;
    always #2 mclk = ~mclk;
    pit_top dut (.mclk_i(mclk), .srst_i(srst), .addr_i(addr), .wr_i(wr), .rd_i(rd),
        .wdata_i(wdata), .rdata_o(rdata), .ext_clk_i(ext_clk), .gate_i(gate),
        .timer_out_o(tout));
    pit_host_bfm host (.mclk_i(mclk), .addr_o(addr), .wr_o(wr), .rd_o(rd),
        .wdata_o(wdata), .rdata_i(rdata));
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic pulse(input int ch, input int n);
        repeat (n) begin
            @(negedge mclk);
            ext_clk[ch] = 1'b1;
            repeat (2) @(negedge mclk);
            ext_clk[ch] = 1'b0;
            repeat (2) @(negedge mclk);
        end
        repeat (4) @(negedge mclk);
    endtask
    task automatic test_done;
        $display("Checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic test_refused;
        host.rd_byte(ADDR_CONTROL, b);
        chk("control read", 16'h0000, {8'h00, b});
        host.rd_byte(3'h0, b);
        chk("unmapped read", 16'h0000, {8'h00, b});
    endtask
    task automatic test_count0;
        host.wr_byte(ADDR_CONTROL, 8'h30);
        host.wr_byte(ADDR_COUNTER0, 8'hAA);
        host.load16(ADDR_COUNTER0, 8'h30, 16'h0005);
        repeat (4) @(negedge mclk);
        chk("out0 armed", 16'h0000, {15'h0, tout[0]});
        pulse(0, 3);
        host.rd16(ADDR_COUNTER0, v);
        chk("count0 live", 16'h0002, v);
        gate[0] = 1'b0;
        pulse(0, 2);
        host.rd16(ADDR_COUNTER0, v);
        chk("count0 gated", 16'h0002, v);
        gate[0] = 1'b1;
        host.wr_byte(ADDR_CONTROL, 8'h00);
        pulse(0, 1);
        host.rd16(ADDR_COUNTER0, v);
        chk("count0 held", 16'h0002, v);
        host.rd16(ADDR_COUNTER0, v);
        chk("count0 released", 16'h0001, v);
        pulse(0, 1);
        chk("out0 terminal", 16'h0001, {15'h0, tout[0]});
    endtask
    task automatic test_modulus;
        logic [7:0]  cw [3] = '{8'h71, 8'h71, 8'h70};
        logic [15:0] ld [3] = '{16'h0010, 16'h0000, 16'h0000};
        logic [15:0] ex [3] = '{16'h0009, 16'h9999, 16'hFFFF};
        for (int i = 0; i < 3; i++) begin
            host.load16(ADDR_COUNTER1, cw[i], ld[i]);
            pulse(1, 1);
            host.rd16(ADDR_COUNTER1, v);
            chk("count1 modulus", ex[i], v);
        end
        host.wr_byte(ADDR_CONTROL, 8'h50);
        host.wr_byte(ADDR_COUNTER1, 8'h12);
        host.rd_byte(ADDR_COUNTER1, b);
        chk("low only", 16'h0012, {8'h00, b});
        host.wr_byte(ADDR_CONTROL, 8'h60);
        host.wr_byte(ADDR_COUNTER1, 8'h34);
        host.rd_byte(ADDR_COUNTER1, b);
        chk("high only", 16'h0034, {8'h00, b});
    endtask
    task automatic test_rate;
        host.load16(ADDR_COUNTER1, 8'h74, 16'h0003);
        pulse(1, 1);
        chk("out1 count 2", 16'h0001, {15'h0, tout[1]});
        pulse(1, 1);
        chk("out1 pulse low", 16'h0000, {15'h0, tout[1]});
        pulse(1, 1);
        chk("out1 after pulse", 16'h0001, {15'h0, tout[1]});
        pulse(1, 2);
        chk("out1 second pulse", 16'h0000, {15'h0, tout[1]});
        gate[1] = 1'b0;
        repeat (4) @(negedge mclk);
        chk("out1 gated high", 16'h0001, {15'h0, tout[1]});
        gate[1] = 1'b1;
        repeat (4) @(negedge mclk);
        host.rd16(ADDR_COUNTER1, v);
        chk("count1 gate reload", 16'h0003, v);
    endtask
    task automatic wait_lvl(input logic lv, output int n);
        n = 0;
        while (tout[2] !== lv && n < 4000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 4000) begin
            errors++;
            $display("Error out2 level expected %0d seen timeout", lv);
        end
    endtask
    task automatic test_square;
        int dv [3] = '{5, 4, 2};
        int n;
        for (int i = 0; i < 3; i++) begin
            host.load16(ADDR_COUNTER2, 8'hB6, 16'(dv[i]));
            wait_lvl(1'b0, n);
            wait_lvl(1'b1, n);
            chk("out2 low", 16'((dv[i] / 2) * INT_CLK_DIV), 16'(n));
            wait_lvl(1'b0, n);
            chk("out2 high", 16'(((dv[i] + 1) / 2) * INT_CLK_DIV), 16'(n));
            wait_lvl(1'b1, n);
        end
    endtask
    initial begin
        repeat (8) @(negedge mclk);
        srst = 1'b0;
        test_refused();
        test_count0();
        test_modulus();
        test_rate();
        test_square();
        test_done();
    end
    initial begin
        repeat (30000) @(posedge mclk);
        errors++;
        test_done();
    end
endmodule // test_pit_top
`default_nettype wire
